//--- include/cid_pkg.sv
package cid_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] CID_IDX_CAPABILITY_IDENTIFICATION = 12'h088;
  localparam logic [11:0] CID_IDX_BUFSTR = 12'h092;
  localparam logic [11:0] CID_IDX_MODE = 12'h051;
  localparam logic [13:0] CID_ADDR_CAPABILITY_IDENTIFICATION = {CID_IDX_CAPABILITY_IDENTIFICATION, 2'b00};
  localparam logic [13:0] CID_ADDR_BUFSTR = {CID_IDX_BUFSTR, 2'b00};
  localparam logic [13:0] CID_ADDR_MODE = {CID_IDX_MODE, 2'b00};

  // capability word and mode register field positions
  localparam int CID_POS_SPEED = 31;
  localparam int CID_POS_DCACHE = 30;
  localparam int CID_POS_AGP = 29;
  localparam int CID_POS_IGFX = 28;
  localparam int CID_POS_VER = 24;
  localparam int CID_POS_LEN = 16;
  localparam int CID_POS_NEXT = 8;
  localparam int CID_POS_TYPE = 0;
  localparam int CID_POS_GMS = 0;

  // constant fields and reset values
  localparam logic [31:0] CID_CAPABILITY_IDENTIFICATION_RESET = 32'hF104A009;
  localparam logic [3:0] CID_VERSION = 4'h1;
  localparam logic [7:0] CID_LENGTH = 8'h04;
  localparam logic [7:0] CID_NEXT_GRAPHICS_PORT = 8'hA0;
  localparam logic [7:0] CID_NEXT_END = 8'h00;
  localparam logic [7:0] CID_TYPE_CODE = 8'h09;
  localparam logic [15:0] CID_BUFSTR_RESET = 16'hFFFF;
  localparam logic CID_GMS_RESET = 1'b0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } cid_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cid_apb_rsp_s;

endpackage

//--- rtl/cid_regs.sv
// Contract
// - capability word read-only, writes ignored
// - bit 31 reports 133 MHz capability
// - bit 30 reports display cache capability
// - bit 29 reports graphics port mode support
// - bit 28 reports integrated graphics support
// - bits 27:24 constant version 0001b
// - bits 23:16 constant length 04h
// - next pointer A0h or 00h by mode
// - bits 7:0 constant vendor capability code
// - word present only in graphics port mode
// - 16-bit buffer strength register, resets ones
`timescale 1ns/1ns
module cid_regs
  import cid_pkg::*;
#(
  parameter logic CAP_133MHZ = 1'b1,
  parameter logic CAP_DISPLAY_CACHE = 1'b1,
  parameter logic CAP_GRAPHICS_PORT = 1'b1,
  parameter logic CAP_INTERNAL_GRAPHICS = 1'b1,
  parameter logic GRAPHICS_PORT_MODE = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire cid_pkg::cid_apb_req_s apb_req,
  output cid_pkg::cid_apb_rsp_s apb_rsp,
  output logic [15:0] memory_buffer_strength,
  output logic graphics_mode_select_bit
);
  import cid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  // address decode
  logic [13:0] word_addr;
  logic addr_in_range;
  logic hit_capability_identification;
  logic hit_bufstr;
  logic hit_mode;
  logic mapped;
  logic [31:0] read_value;

  // capability word
  logic [31:0] capability_identification;
  logic [7:0] chain_pointer;

  // access and write qualifiers
  logic access_wait;
  logic wr_take;
  logic wr_bufstr;
  logic wr_bufstr_low;
  logic wr_bufstr_high;
  logic wr_mode;

  // bus response group
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // buffer strength group
  logic [7:0] next_bufstr_low;
  logic [7:0] next_bufstr_high;
  logic [15:0] next_memory_buffer_strength;

  // mode bit group
  logic next_graphics_mode_select_bit;

  ////////////////////////////////////////////////////////////////////////////
  // capability word

  always_comb
  begin
    capability_identification = '0;
    capability_identification[CID_POS_SPEED] = CAP_133MHZ;
    capability_identification[CID_POS_DCACHE] = CAP_DISPLAY_CACHE;
    capability_identification[CID_POS_AGP] = CAP_GRAPHICS_PORT;
    capability_identification[CID_POS_IGFX] = CAP_INTERNAL_GRAPHICS;
    capability_identification[CID_POS_VER +: 4] = CID_VERSION;
    capability_identification[CID_POS_LEN +: 8] = CID_LENGTH;
    // pointer is taken from the live mode bit, not a stored copy
    capability_identification[CID_POS_NEXT +: 8] = chain_pointer;
    capability_identification[CID_POS_TYPE +: 8] = CID_TYPE_CODE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  always_comb
  begin
    word_addr = {apb_req.paddr[13:2], 2'b00};
    // any set bit above the window would otherwise alias a register
    addr_in_range = (apb_req.paddr[31:14] == '0);
    hit_capability_identification = 1'b0;
    hit_bufstr = 1'b0;
    hit_mode = 1'b0;
    if (addr_in_range)
    begin
      case (word_addr)
        CID_ADDR_CAPABILITY_IDENTIFICATION:
        begin
          hit_capability_identification = GRAPHICS_PORT_MODE;
        end
        CID_ADDR_BUFSTR:
        begin
          hit_bufstr = 1'b1;
        end
        CID_ADDR_MODE:
        begin
          hit_mode = 1'b1;
        end
        default:
        begin
          hit_mode = 1'b0;
        end
      endcase
    end
    mapped = hit_capability_identification || hit_bufstr || hit_mode;
  end

  always_comb
  begin
    read_value = 32'h00000000;
    if (hit_capability_identification)
    begin
      read_value = capability_identification;
    end
    else if (hit_bufstr)
    begin
      read_value = {16'h0000, memory_buffer_strength};
    end
    else if (hit_mode)
    begin
      read_value = {31'h00000000, graphics_mode_select_bit};
    end
  end

  always_comb
  begin
    case (graphics_mode_select_bit)
      1'b0:
      begin
        chain_pointer = CID_NEXT_GRAPHICS_PORT;
      end
      1'b1:
      begin
        chain_pointer = CID_NEXT_END;
      end
      default:
      begin
        chain_pointer = CID_NEXT_GRAPHICS_PORT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus response

  always_comb
  begin
    access_wait = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    wr_take = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && mapped;
    // the capability word has no storage, so a write to it lands nowhere
    wr_bufstr = wr_take && hit_bufstr;
    wr_bufstr_low = wr_bufstr && apb_req.pstrb[0];
    wr_bufstr_high = wr_bufstr && apb_req.pstrb[1];
    wr_mode = wr_take && hit_mode && apb_req.pstrb[0];
  end

  always_comb
  begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // read data holds between transfers; only pready qualifies it
    next_prdata = apb_rsp.prdata;
    // one wait state: answer on the second access cycle
    if (access_wait)
    begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      if (apb_req.pwrite)
      begin
        next_prdata = 32'h00000000;
      end
      else
      begin
        next_prdata = read_value;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_rsp <= '0;
    end
    else
    begin
      apb_rsp.prdata <= next_prdata;
      apb_rsp.pready <= next_pready;
      apb_rsp.pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer strength register
  // strobe lanes 3:2 have no storage behind them and are dropped

  cid_strobe_lane
  #(
    .WIDTH(8)
  )
  low_lane_inst
  (
    .strobe(wr_bufstr_low),
    .current(memory_buffer_strength[7:0]),
    .wdata(apb_req.pwdata[7:0]),
    .next_value(next_bufstr_low)
  );

  cid_strobe_lane
  #(
    .WIDTH(8)
  )
  high_lane_inst
  (
    .strobe(wr_bufstr_high),
    .current(memory_buffer_strength[15:8]),
    .wdata(apb_req.pwdata[15:8]),
    .next_value(next_bufstr_high)
  );

  always_comb
  begin
    next_memory_buffer_strength = {next_bufstr_high, next_bufstr_low};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      memory_buffer_strength <= CID_BUFSTR_RESET;
    end
    else
    begin
      memory_buffer_strength <= next_memory_buffer_strength;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // graphics mode select register: 0 graphics port mode, 1 internal graphics mode

  always_comb
  begin
    next_graphics_mode_select_bit = graphics_mode_select_bit;
    if (wr_mode)
    begin
      next_graphics_mode_select_bit = apb_req.pwdata[CID_POS_GMS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      graphics_mode_select_bit <= CID_GMS_RESET;
    end
    else
    begin
      graphics_mode_select_bit <= next_graphics_mode_select_bit;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// one write-strobed lane of a read/write register

module cid_strobe_lane
#(
  parameter int WIDTH = 8
)
(
  input wire logic strobe,
  input wire logic [WIDTH-1:0] current,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] next_value
);
  import cid_pkg::*;

  always_comb
  begin
    // an unstrobed lane keeps its stored value
    next_value = current;
    if (strobe)
    begin
      next_value = wdata;
    end
  end

endmodule

//--- tb/cid_regs_checker.sv
`timescale 1ns/1ns
module cid_regs_checker
  import cid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire cid_pkg::cid_apb_req_s apb_req,
  input wire cid_pkg::cid_apb_rsp_s apb_rsp,
  input wire logic [15:0] memory_buffer_strength,
  input wire logic graphics_mode_select_bit
);
  wire [31:0] d = apb_rsp.prdata;
  wire [31:0] a = apb_req.paddr;
  wire rd = apb_rsp.pready & apb_req.psel & !apb_req.pwrite;
  wire wr = apb_rsp.pready & apb_req.psel & apb_req.pwrite;
  wire cap = rd && a == 32'h220;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("late");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("long");
  chk_word_top: assert property (cap |-> d[31:16] == 16'hF104)
    else $error("top");
  chk_type_code: assert property (cap |-> d[7:0] == 8'h09 && !apb_rsp.pslverr)
    else $error("type");
  chk_next_ptr: assert property (cap |-> d[15:8] == (graphics_mode_select_bit ? 8'h00 : 8'hA0))
    else $error("next");
  chk_buf_cause: assert property ($changed(memory_buffer_strength) |-> $past(wr && a == 32'h248))
    else $error("buf");
  chk_buf_read: assert property (rd && a == 32'h248 |-> d == {16'h0, memory_buffer_strength})
    else $error("rd");
  chk_mode_cause: assert property ($changed(graphics_mode_select_bit) |-> $past(wr && a == 32'h144))
    else $error("mode");
endmodule
bind cid_regs cid_regs_checker cid_regs_checker_inst (.pclk, .presetn, .apb_req, .apb_rsp, .memory_buffer_strength,
  .graphics_mode_select_bit);

//--- tb/test_capability_id_register.sv
`timescale 1ns/1ns
module test_capability_id_register;
  import cid_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  cid_apb_req_s req = '0;
  cid_apb_rsp_s rsp;
  logic [15:0] mbs;
  logic gms;
  logic [31:0] lf = 32'h464B2305;
  logic [31:0] ex;
  logic [31:0] at [4] = '{32'h220, 32'h248, 32'h144, 32'h10220};
  int mismatches = 0;
  int n_checks = 0;
  int bm = 'hFFFF;
  int mm = 0;
  cid_regs cid_regs_inst (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .memory_buffer_strength(mbs),
    .graphics_mode_select_bit(gms));
  initial forever #4 pclk = ~pclk;
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task op(input logic w, input int k, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, at[k], d, s};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    ex = k == 0 ? {16'hF104, mm ? 8'h00 : 8'hA0, 8'h09} : k == 1 ? bm : k == 2 ? mm : 0;
    if (!w) chk(rsp.prdata, ex);
    chk({31'h0, rsp.pslverr}, 32'(k == 3));
    if (w && k == 1) bm = {s[1] ? d[15:8] : bm[15:8], s[0] ? d[7:0] : bm[7:0]};
    if (w && k == 2 && s[0]) mm = d[0];
    req <= '0;
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    chk({16'h0, mbs}, 32'hFFFF);
    chk({31'h0, gms}, 32'h0);
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++) op(0, k, 0, 0);
    op(1, 2, 1, 1);
    op(0, 0, 0, 0);
    repeat (60)
    begin
      lf = lfsr(lf);
      op(lf[0], int'(lf[2:1]), lfsr(lf), lf[7:4]);
    end
    @(posedge pclk);
    chk({16'h0, mbs}, bm);
    chk({31'h0, gms}, mm);
    give_verdict;
  end
  initial
  begin
    repeat (2000) @(posedge pclk);
    mismatches++;
    give_verdict;
  end
endmodule
